// ==== include/dftm_pkg.sv ====
// Purpose: Shared constants for the drive fault trip manager.
// Assumes: 10 MHz system clock, APB register access with 32-bit data.
// Notes:   Trip bit positions are shared by the trip vector and the registers.
package dftm_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned KPD_LOSS_MS     = 2000;
    localparam int unsigned BRAKE_LOW_MS    = 10000;
    localparam int unsigned KPD_LOSS_CYC    = KPD_LOSS_MS * (CLK_HZ / 1000);
    localparam int unsigned BRAKE_LOW_CYC   = BRAKE_LOW_MS * (CLK_HZ / 1000);
    localparam int unsigned NUM_TERM        = 8;
    localparam int unsigned NUM_TRIP        = 20;

    localparam logic [3:0]  TERM_FN_EXT_TRIP = 4'h3;
    localparam logic [3:0]  TERM_FN_BLOCK    = 4'h4;
    localparam logic [1:0]  CTRL_VF          = 2'h0;
    localparam logic [1:0]  CTRL_SLESS1      = 2'h1;
    localparam logic [1:0]  CTRL_SLESS2      = 2'h2;
    localparam logic [1:0]  CTRL_VECTOR      = 2'h3;

    localparam int unsigned T_EXT      = 0;
    localparam int unsigned T_BLOCK    = 1;
    localparam int unsigned T_HWDIAG   = 2;
    localparam int unsigned T_FAN      = 3;
    localparam int unsigned T_THERM    = 4;
    localparam int unsigned T_OVSPD    = 5;
    localparam int unsigned T_DEVSPD   = 6;
    localparam int unsigned T_ENC      = 7;
    localparam int unsigned T_PREREG   = 8;
    localparam int unsigned T_BRAKE    = 9;
    localparam int unsigned T_KPD      = 10;
    localparam int unsigned T_CMD      = 11;
    localparam int unsigned T_OPT1     = 12;
    localparam int unsigned T_OPT2     = 13;
    localparam int unsigned T_OPT3     = 14;
    localparam int unsigned T_IOB      = 15;
    localparam int unsigned T_PWRITE   = 16;
    localparam int unsigned T_OC2      = 17;
    localparam int unsigned T_OVHEAT   = 18;
    localparam int unsigned T_NTC      = 19;

    localparam logic [19:0] LEVEL_MASK = 20'h00C02;
    localparam logic [19:0] FATAL_MASK = 20'h00004;

    localparam logic [11:0] A_TRIP_STAT   = 12'h000;
    localparam logic [11:0] A_HISTORY     = 12'h004;
    localparam logic [11:0] A_CFG_SEL     = 12'h008;
    localparam logic [11:0] A_TERM_FN     = 12'h00C;
    localparam logic [11:0] A_OVSPD_LVL   = 12'h010;
    localparam logic [11:0] A_BRAKE_CUR   = 12'h014;
    localparam logic [11:0] A_NOLOAD_CUR  = 12'h018;
    localparam logic [11:0] A_ENC_TIME    = 12'h01C;
    localparam logic [11:0] A_RESET_CMD   = 12'h020;

    localparam logic [31:0] CFG_SEL_RST   = 32'h0000_0000;
    localparam logic [31:0] TERM_FN_RST   = 32'h0000_0000;
    localparam logic [15:0] OVSPD_RST     = 16'hFFFF;
    localparam logic [15:0] CUR_RST       = 16'h0000;
    localparam logic [23:0] ENC_TIME_RST  = 24'h00_2710;

    localparam int unsigned CFG_FAN_SEL    = 0;
    localparam int unsigned CFG_THERM_SEL  = 1;
    localparam int unsigned CFG_DEV_EN     = 2;
    localparam int unsigned CFG_ENC_EN     = 3;
    localparam int unsigned CFG_KPD_ACT    = 4;
    localparam int unsigned CFG_CMD_ACT    = 5;
    localparam int unsigned CFG_BRK_ASSIGN = 6;
    localparam int unsigned CFG_CTRL_LSB   = 8;
endpackage

// ==== core/dftm_persist.sv ====
// Purpose: Persistence timer: output rises once the condition held for a set count.
// Assumes: Synchronous condition input, limit sampled every cycle.
// Notes:   A condition drop restarts the count, so glitches never accumulate.
module dftm_persist #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    output logic              hit
);
    logic [W-1:0] cnt_r;
    wire          at_lim = (cnt_r >= limit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!cond) begin
            cnt_r <= '0;
        end else if (!at_lim) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign hit = cond && at_lim;
endmodule

// ==== core/dftm_top.sv ====
// Purpose: Fault trip supervisor, sorts trips into level, latched and fatal classes.
// Assumes: Condition flags arrive synchronous to sys_clk from sensors and boards.
// Notes:   Registers over APB; fatal trips clear only by power-on reset.
// Operation
// [RULE1] Level trips self-clear, never enter history.
// [RULE2] Latched trips hold until reset input.
// [RULE3] Fatal trips cleared only by power cycle.
// [RULE4] Terminal function 3 raises latched external trip.
// [RULE5] Terminal function 4 blocks output, level.
// [RULE6] Hardware diagnostic errors raise fatal trip.
// [RULE7] Fan error trips when fan select zero.
// [RULE8] External thermistor over limit trips when enabled.
// [RULE9] Speed above overspeed level trips latched.
// [RULE10] Enabled speed deviation raises latched trip.
// [RULE11] Persistent encoder abnormality raises latched trip.
// [RULE12] Low pre-regulation feedback raises latched trip.
// [RULE13] Open-loop brake current low ten seconds trips.
// [RULE14] Vector brake current below half no-load trips.
// [RULE15] Keypad loss two seconds raises level trip.
// [RULE16] Non-keypad command loss raises level trip.
// [RULE17] Each option slot has own trip.
// [RULE18] I/O board link fault raises latched trip.
// [RULE19] Parameter write link failure raises latched trip.
// [RULE20] DC short-circuit current raises latched trip.
// [RULE21] Heat sink overtemperature raises latched trip.
// [RULE22] Power-switch sensor fault raises latched trip.
// [RULE23] Combined trip output ORs all trips.
module dftm_top #(
    parameter int unsigned KPD_LOSS_CYC  = dftm_pkg::KPD_LOSS_CYC,
    parameter int unsigned BRAKE_LOW_CYC = dftm_pkg::BRAKE_LOW_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  term_in,
    input  wire logic        trip_reset_in,
    input  wire logic        param_store_error,
    input  wire logic        adc_offset_err,
    input  wire logic        gate_supply_loss,
    input  wire logic        watchdog1_err,
    input  wire logic        watchdog2_err,
    input  wire logic        fan_err,
    input  wire logic        below_22kw,
    input  wire logic        thermistor_over,
    input  wire logic [15:0] motor_speed,
    input  wire logic        speed_dev_over,
    input  wire logic        encoder_abnormal,
    input  wire logic        prereg_active,
    input  wire logic        prereg_fb_low,
    input  wire logic [15:0] output_current,
    input  wire logic        cmd_from_keypad,
    input  wire logic        keypad_link_ok,
    input  wire logic        running,
    input  wire logic        cmd_lost,
    input  wire logic [2:0]  opt_installed,
    input  wire logic [2:0]  opt_link_ok,
    input  wire logic        io_board_fault,
    input  wire logic        param_write_fail,
    input  wire logic        dc_short_current,
    input  wire logic        heatsink_over,
    input  wire logic        ntc_fault,
    output logic             trip_active,
    output logic             output_block_input,
    output logic      [19:0] trip_vec
);
    localparam int unsigned NT = dftm_pkg::NUM_TRIP;

    logic        rs1_r;
    logic        rs2_r;
    wire         rst_n = rs2_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    logic [31:0]   cfg_r;
    logic [31:0]   term_fn_r;
    logic [15:0]   ovspd_r;
    logic [15:0]   brake_cur_r;
    logic [15:0]   noload_cur_r;
    logic [23:0]   enc_time_r;
    logic [NT-1:0] latch_r;
    logic [NT-1:0] hist_r;
    logic [2:0]    opt_seen_r;
    logic          sw_reset_r;

    function automatic logic term_has(input logic [31:0] fn, input logic [7:0] t, input logic [3:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (fn[i*4 +: 4] == code && t[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    wire [1:0] ctrl_mode = cfg_r[dftm_pkg::CFG_CTRL_LSB +: 2];
    wire       open_loop = (ctrl_mode == dftm_pkg::CTRL_VF) || (ctrl_mode == dftm_pkg::CTRL_SLESS1)
                           || (ctrl_mode == dftm_pkg::CTRL_SLESS2);
    wire       vector    = (ctrl_mode == dftm_pkg::CTRL_VECTOR);
    wire       brk_asg   = cfg_r[dftm_pkg::CFG_BRK_ASSIGN];

    wire       brake_low_ol = open_loop && brk_asg && (output_current < brake_cur_r);
    wire       brake_hit_ol;
    wire       kpd_lost     = cfg_r[dftm_pkg::CFG_KPD_ACT] && cmd_from_keypad && !keypad_link_ok;
    wire       kpd_hit;
    wire       enc_cond     = cfg_r[dftm_pkg::CFG_ENC_EN] && encoder_abnormal;
    wire       enc_hit;

    // Brake current timer needs 27 bits at the 10 s default.
    dftm_persist #(.W(32)) u_brake (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .cond  (brake_low_ol),
        .limit (BRAKE_LOW_CYC),
        .hit   (brake_hit_ol)
    ); // [RULE13]

    dftm_persist #(.W(32)) u_kpd (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .cond  (kpd_lost),
        .limit (KPD_LOSS_CYC),
        .hit   (kpd_hit)
    ); // [RULE15]

    dftm_persist #(.W(24)) u_enc (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .cond  (enc_cond),
        .limit (enc_time_r),
        .hit   (enc_hit)
    ); // [RULE11]

    logic [NT-1:0] cond;
    always_comb begin
        cond = '0;
        cond[dftm_pkg::T_EXT]    = term_has(term_fn_r, term_in, dftm_pkg::TERM_FN_EXT_TRIP); // [RULE4]
        cond[dftm_pkg::T_BLOCK]  = term_has(term_fn_r, term_in, dftm_pkg::TERM_FN_BLOCK); // [RULE5]
        cond[dftm_pkg::T_HWDIAG] = param_store_error | adc_offset_err | gate_supply_loss
                                   | watchdog1_err | watchdog2_err; // [RULE6]
        cond[dftm_pkg::T_FAN]    = fan_err && below_22kw && !cfg_r[dftm_pkg::CFG_FAN_SEL]; // [RULE7]
        cond[dftm_pkg::T_THERM]  = cfg_r[dftm_pkg::CFG_THERM_SEL] && thermistor_over; // [RULE8]
        cond[dftm_pkg::T_OVSPD]  = motor_speed > ovspd_r; // [RULE9]
        cond[dftm_pkg::T_DEVSPD] = cfg_r[dftm_pkg::CFG_DEV_EN] && speed_dev_over; // [RULE10]
        cond[dftm_pkg::T_ENC]    = enc_hit; // [RULE11]
        cond[dftm_pkg::T_PREREG] = prereg_active && prereg_fb_low; // [RULE12]
        cond[dftm_pkg::T_BRAKE]  = brake_hit_ol
                                   || (vector && brk_asg && (output_current < {1'b0, noload_cur_r[15:1]})); // [RULE14]
        cond[dftm_pkg::T_KPD]    = kpd_hit; // [RULE15]
        cond[dftm_pkg::T_CMD]    = cfg_r[dftm_pkg::CFG_CMD_ACT] && !cmd_from_keypad && running && cmd_lost; // [RULE16]
        for (int s = 0; s < 3; s++) begin
            cond[dftm_pkg::T_OPT1 + s] = opt_seen_r[s] && (!opt_installed[s] || !opt_link_ok[s]); // [RULE17]
        end
        cond[dftm_pkg::T_IOB]    = io_board_fault; // [RULE18]
        cond[dftm_pkg::T_PWRITE] = param_write_fail; // [RULE19]
        cond[dftm_pkg::T_OC2]    = dc_short_current; // [RULE20]
        cond[dftm_pkg::T_OVHEAT] = heatsink_over; // [RULE21]
        cond[dftm_pkg::T_NTC]    = ntc_fault; // [RULE22]
    end

    wire           reset_req = trip_reset_in | sw_reset_r;
    wire [NT-1:0]  stick     = ~dftm_pkg::LEVEL_MASK;
    wire [NT-1:0]  clr_mask  = reset_req ? ~dftm_pkg::FATAL_MASK : '0;
    // A condition still present during reset wins, so the trip stays up.
    wire [NT-1:0]  latch_nxt = ((latch_r & ~clr_mask) | cond) & stick; // [RULE2] [RULE3]
    wire [NT-1:0]  trips     = latch_r | (cond & dftm_pkg::LEVEL_MASK); // [RULE1]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r    <= '0;
            hist_r     <= '0;
            opt_seen_r <= 3'h0;
        end else begin
            latch_r    <= latch_nxt;
            hist_r     <= hist_r | (cond & stick); // [RULE1]
            opt_seen_r <= (opt_seen_r | (opt_installed & opt_link_ok)) & opt_installed; // [RULE17]
        end
    end

    assign trip_vec           = trips;
    assign trip_active        = |trips; // [RULE23]
    assign output_block_input = trips[dftm_pkg::T_BLOCK]; // [RULE5]

    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire known   = (paddr == dftm_pkg::A_TRIP_STAT) || (paddr == dftm_pkg::A_HISTORY)
                   || (paddr == dftm_pkg::A_CFG_SEL) || (paddr == dftm_pkg::A_TERM_FN)
                   || (paddr == dftm_pkg::A_OVSPD_LVL) || (paddr == dftm_pkg::A_BRAKE_CUR)
                   || (paddr == dftm_pkg::A_NOLOAD_CUR) || (paddr == dftm_pkg::A_ENC_TIME)
                   || (paddr == dftm_pkg::A_RESET_CMD);
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            dftm_pkg::A_TRIP_STAT:  rd_mux = {12'h000, trips};
            dftm_pkg::A_HISTORY:    rd_mux = {12'h000, hist_r};
            dftm_pkg::A_CFG_SEL:    rd_mux = cfg_r;
            dftm_pkg::A_TERM_FN:    rd_mux = term_fn_r;
            dftm_pkg::A_OVSPD_LVL:  rd_mux = {16'h0000, ovspd_r};
            dftm_pkg::A_BRAKE_CUR:  rd_mux = {16'h0000, brake_cur_r};
            dftm_pkg::A_NOLOAD_CUR: rd_mux = {16'h0000, noload_cur_r};
            dftm_pkg::A_ENC_TIME:   rd_mux = {8'h00, enc_time_r};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = acc && !known;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r        <= dftm_pkg::CFG_SEL_RST;
            term_fn_r    <= dftm_pkg::TERM_FN_RST;
            ovspd_r      <= dftm_pkg::OVSPD_RST;
            brake_cur_r  <= dftm_pkg::CUR_RST;
            noload_cur_r <= dftm_pkg::CUR_RST;
            enc_time_r   <= dftm_pkg::ENC_TIME_RST;
            sw_reset_r   <= 1'b0;
            prdata       <= 32'h0000_0000;
        end else begin
            sw_reset_r <= wr && (paddr == dftm_pkg::A_RESET_CMD) && pwdata[0];
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
            if (wr && paddr == dftm_pkg::A_CFG_SEL)    cfg_r        <= pwdata;
            if (wr && paddr == dftm_pkg::A_TERM_FN)    term_fn_r    <= pwdata;
            if (wr && paddr == dftm_pkg::A_OVSPD_LVL)  ovspd_r      <= pwdata[15:0];
            if (wr && paddr == dftm_pkg::A_BRAKE_CUR)  brake_cur_r  <= pwdata[15:0];
            if (wr && paddr == dftm_pkg::A_NOLOAD_CUR) noload_cur_r <= pwdata[15:0];
            if (wr && paddr == dftm_pkg::A_ENC_TIME)   enc_time_r   <= pwdata[23:0];
        end
    end
endmodule

// ==== verif/dftm_chk.sv ====
// Purpose: Checker of trip classes and combined trip output at the top ports.
// Assumes: Bound to dftm_top; rstn low disables every assertion.
// Notes:   Any write to the reset command is taken as a possible clear.
module dftm_chk #(
    parameter int unsigned KPD_LOSS_CYC  = 20,
    parameter int unsigned BRAKE_LOW_CYC = 50
) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [7:0]  term_in,
    input wire logic        trip_reset_in,
    input wire logic        adc_offset_err,
    input wire logic        dc_short_current,
    input wire logic        keypad_link_ok,
    input wire logic        running,
    input wire logic        cmd_lost,
    input wire logic        trip_active,
    input wire logic        output_block_input,
    input wire logic [19:0] trip_vec
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] LAT = ~(dftm_pkg::LEVEL_MASK | dftm_pkg::FATAL_MASK);
    logic [1:0] up_r;
    logic       swr;
    // The internal reset copy lags rstn, so set checks wait three edges.
    assign swr = psel && penable && pwrite && (paddr == dftm_pkg::A_RESET_CMD);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking dck @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_latch_hold: assert property (!trip_reset_in && !swr && !$past(swr) |=> ((trip_vec & LAT) & $past(trip_vec & LAT)) == $past(trip_vec & LAT)) else $error("latched trip dropped");
    a_fatal_hold: assert property (trip_vec[2] |=> trip_vec[2]) else $error("fatal trip dropped");
    a_fatal_set: assert property (up_r == 2'h3 && adc_offset_err |=> trip_vec[2]) else $error("fatal trip not raised");
    a_short_set: assert property (up_r == 2'h3 && dc_short_current |=> trip_vec[17]) else $error("short trip missing");
    a_ext_clear: assert property (trip_reset_in && term_in == 8'h00 |=> !trip_vec[0]) else $error("ext trip kept");
    a_block_idle: assert property (term_in == 8'h00 |-> !output_block_input) else $error("block without input");
    a_cmd_level: assert property (!(running && cmd_lost) [*2] |-> !trip_vec[11]) else $error("cmd trip kept");
    a_kpd_level: assert property (keypad_link_ok [*2] |-> !trip_vec[10]) else $error("keypad trip kept");
    a_trip_or: assert property (trip_active == (|trip_vec)) else $error("trip_active is not the OR");
endmodule

// ==== verif/dftm_far_model.sv ====
// Purpose: Option cards and keypad link as seen from the drive.
// Assumes: Bench seats, unseats or cuts links at rising edges.
// Notes:   A seated card brings its link up one cycle late, as a real card does.
module dftm_far_model (
    input  wire logic       clk,
    input  wire logic [2:0] seat,
    input  wire logic [2:0] cut,
    input  wire logic       kpd_off,
    output logic      [2:0] inst   = 3'h0,
    output logic      [2:0] link   = 3'h0,
    output logic            kpd_ok = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk) begin
        inst <= seat;
        link <= seat & inst & ~cut;
        kpd_ok <= ~kpd_off;
    end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench of the fault trip manager.
// Assumes: Short keypad and brake counts set by parameters.
// Notes:   Trip vector bits are sampled at the falling edge, away from register updates; bus, active/block outputs and the opt_own slot word at the rising edge.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned KPD = 20;
    localparam int unsigned BRK = 50;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [7:0]  term    = 8'h00;
    logic        trst    = 1'b0;
    logic [19:0] cv      = 20'h00000;
    logic [4:0]  hw      = 5'h00;
    logic [15:0] spd     = 16'h0000;
    logic [15:0] cur     = 16'hFFFF;
    logic        kp      = 1'b0;
    logic        cl      = 1'b0;
    logic        kpd_off = 1'b0;
    logic        lowkw   = 1'b1;
    logic        preon   = 1'b1;
    logic [2:0]  seat    = 3'h0;
    logic [2:0]  cut     = 3'h0;
    logic [31:0] prdata, rd;
    logic [19:0] tv;
    logic [2:0]  inst, link;
    logic        pready, pslverr, serr, kok, trip_active, output_block_input;
    int          err_count = 0;
    int          compares  = 0;
    int          cyc       = 0;
    int          lb[9]     = '{3, 4, 6, 8, 15, 16, 17, 18, 19};
    always #50 sys_clk = ~sys_clk;
    dftm_top #(.KPD_LOSS_CYC(KPD), .BRAKE_LOW_CYC(BRK)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term_in(term), .trip_reset_in(trst), .param_store_error(hw[0]), .adc_offset_err(hw[1]),
        .gate_supply_loss(hw[2]), .watchdog1_err(hw[3]), .watchdog2_err(hw[4]), .fan_err(cv[3]), .below_22kw(lowkw),
        .thermistor_over(cv[4]), .motor_speed(spd), .speed_dev_over(cv[6]), .encoder_abnormal(cv[7]),
        .prereg_active(preon), .prereg_fb_low(cv[8]), .output_current(cur), .cmd_from_keypad(kp),
        .keypad_link_ok(kok), .running(cl), .cmd_lost(cl), .opt_installed(inst), .opt_link_ok(link),
        .io_board_fault(cv[15]), .param_write_fail(cv[16]), .dc_short_current(cv[17]), .heatsink_over(cv[18]),
        .ntc_fault(cv[19]), .trip_active(trip_active), .output_block_input(output_block_input), .trip_vec(tv));
    dftm_far_model i_far (.clk(sys_clk), .seat(seat), .cut(cut), .kpd_off(kpd_off), .inst(inst), .link(link),
        .kpd_ok(kok));
    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic ckn(input string nm, input int b, input logic e);
        @(negedge sys_clk);
        ck(nm, {31'h0, tv[b]}, {31'h0, e});
        @(posedge sys_clk);
    endtask
    // Request is held until pready is seen high; the global cycle limit ends a hang.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        ck(nm, rd, e);
    endtask
    task automatic pin_rst();
        trst <= 1'b1;
        cy(1);
        trst <= 1'b0;
        cy(1);
    endtask
    task automatic lat(input int b);
        cv[b] <= 1'b1;
        cy(1);
        cv[b] <= 1'b0;
        cy(1);
        ckn("latched", b, 1'b1);
        pin_rst();
        ckn("cleared", b, 1'b0);
    endtask
    initial begin
        cy(2);
        rstn <= 1'b1;
        cy(4);
        rc("cfg", dftm_pkg::A_CFG_SEL, dftm_pkg::CFG_SEL_RST);
        rc("ovspd", dftm_pkg::A_OVSPD_LVL, {16'h0000, dftm_pkg::OVSPD_RST});
        rc("enc", dftm_pkg::A_ENC_TIME, {8'h00, dftm_pkg::ENC_TIME_RST});
        rc("hole", 12'h040, 32'h0000_0000);
        ck("slverr", {31'h0, serr}, 32'h0000_0001);
        apb(1'b1, dftm_pkg::A_TERM_FN, 32'h0000_0043);
        term <= 8'h01;
        cy(1);
        term <= 8'h02;
        ckn("ext", dftm_pkg::T_EXT, 1'b1);
        ck("active", {31'h0, trip_active}, 32'h0000_0001);
        ck("block", {31'h0, output_block_input}, 32'h0000_0001);
        term <= 8'h00;
        ckn("unblock", dftm_pkg::T_BLOCK, 1'b0);
        ckn("ext_hold", dftm_pkg::T_EXT, 1'b1);
        rc("hist", dftm_pkg::A_HISTORY, 32'h0000_0001);
        apb(1'b1, dftm_pkg::A_RESET_CMD, 32'h0000_0001);
        ckn("ext_sw", dftm_pkg::T_EXT, 1'b0);
        term <= 8'h01;
        cy(1);
        term <= 8'h00;
        ckn("ext_again", dftm_pkg::T_EXT, 1'b1);
        pin_rst();
        ckn("ext_pin", dftm_pkg::T_EXT, 1'b0);
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0006);
        foreach (lb[i]) lat(lb[i]);
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0001);
        cv[3] <= 1'b1;
        cy(1);
        cv[3] <= 1'b0;
        ckn("fan_off", dftm_pkg::T_FAN, 1'b0);
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0000);
        lowkw <= 1'b0;
        preon <= 1'b0;
        cv[3] <= 1'b1;
        cv[8] <= 1'b1;
        cy(1);
        cv <= 20'h00000;
        lowkw <= 1'b1;
        preon <= 1'b1;
        ckn("fan_big", dftm_pkg::T_FAN, 1'b0);
        ckn("prereg_idle", dftm_pkg::T_PREREG, 1'b0);
        apb(1'b1, dftm_pkg::A_OVSPD_LVL, 32'h0000_0064);
        spd <= 16'h0064;
        cy(2);
        ckn("ovspd_eq", dftm_pkg::T_OVSPD, 1'b0);
        spd <= 16'h0065;
        cy(1);
        spd <= 16'h0000;
        ckn("ovspd", dftm_pkg::T_OVSPD, 1'b1);
        pin_rst();
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0008);
        apb(1'b1, dftm_pkg::A_ENC_TIME, 32'h0000_0005);
        cv[7] <= 1'b1;
        cy(3);
        cv[7] <= 1'b0;
        ckn("enc_short", dftm_pkg::T_ENC, 1'b0);
        cv[7] <= 1'b1;
        cy(8);
        cv[7] <= 1'b0;
        ckn("enc", dftm_pkg::T_ENC, 1'b1);
        pin_rst();
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0040);
        apb(1'b1, dftm_pkg::A_BRAKE_CUR, 32'h0000_0032);
        apb(1'b1, dftm_pkg::A_NOLOAD_CUR, 32'h0000_0064);
        cur <= 16'h0031;
        cy(BRK - 10);
        cur <= 16'hFFFF;
        ckn("brk_early", dftm_pkg::T_BRAKE, 1'b0);
        cur <= 16'h0031;
        cy(BRK + 10);
        cur <= 16'hFFFF;
        ckn("brk", dftm_pkg::T_BRAKE, 1'b1);
        pin_rst();
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0340);
        cur <= 16'h0032;
        cy(3);
        ckn("vec_eq", dftm_pkg::T_BRAKE, 1'b0);
        cur <= 16'h0031;
        cy(1);
        cur <= 16'hFFFF;
        ckn("vec", dftm_pkg::T_BRAKE, 1'b1);
        pin_rst();
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0010);
        kp <= 1'b1;
        kpd_off <= 1'b1;
        cy(KPD - 10);
        ckn("kpd_early", dftm_pkg::T_KPD, 1'b0);
        cy(15);
        ckn("kpd", dftm_pkg::T_KPD, 1'b1);
        kpd_off <= 1'b0;
        cy(3);
        ckn("kpd_back", dftm_pkg::T_KPD, 1'b0);
        kp <= 1'b0;
        apb(1'b1, dftm_pkg::A_CFG_SEL, 32'h0000_0020);
        cl <= 1'b1;
        cy(2);
        ckn("cmd", dftm_pkg::T_CMD, 1'b1);
        cl <= 1'b0;
        cy(2);
        ckn("cmd_off", dftm_pkg::T_CMD, 1'b0);
        // History is sticky: every latched cause raised so far stays, no level cause appears.
        rc("hist_lvl", dftm_pkg::A_HISTORY, 32'h000F_83F9);
        ck("hist_mask", rd & {12'h000, dftm_pkg::LEVEL_MASK}, 32'h0000_0000);
        seat <= 3'h7;
        cy(4);
        for (int s = 0; s < 6; s++) begin
            if (s < 3) seat[s] <= 1'b0;
            else cut[s - 3] <= 1'b1;
            cy(2);
            ckn("opt", 12 + (s % 3), 1'b1);
            ck("opt_own", {29'h0, tv[14:12]}, 32'h0000_0001 << (s % 3));
            seat <= 3'h7;
            cut <= 3'h0;
            cy(3);
            pin_rst();
            ckn("opt_clr", 12 + (s % 3), 1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            hw[i] <= 1'b1;
            cy(1);
            hw[i] <= 1'b0;
            pin_rst();
            apb(1'b1, dftm_pkg::A_RESET_CMD, 32'h0000_0001);
            ckn("fatal", dftm_pkg::T_HWDIAG, 1'b1);
            rstn <= 1'b0;
            cy(2);
            rstn <= 1'b1;
            cy(4);
            ckn("fatal_clr", dftm_pkg::T_HWDIAG, 1'b0);
        end
        stop_test();
    end
endmodule
bind dftm_top dftm_chk #(.KPD_LOSS_CYC(KPD_LOSS_CYC), .BRAKE_LOW_CYC(BRAKE_LOW_CYC)) i_chk (.sys_clk, .rstn,
    .psel, .penable, .pwrite, .paddr, .term_in, .trip_reset_in, .adc_offset_err, .dc_short_current,
    .keypad_link_ok, .running, .cmd_lost, .trip_active, .output_block_input, .trip_vec);
